/* File: rtl/ampc_pkg.sv */
// Constants, register map and types of the amplifier control logic.
// Assumes a 200 MHz system clock; shared by all ampc modules.
package ampc_pkg;

    localparam int CLK_FREQ_HZ = 200_000_000;

    // Beep detector: gap without an edge that ends a beep, in microseconds
    localparam int BEEP_GAP_US  = 10000;
    localparam int BEEP_GAP_CYC = BEEP_GAP_US * (CLK_FREQ_HZ / 1_000_000);
    localparam logic [1:0] BEEP_MIN_EDGES = 2'h3;

    // Pin vector positions
    localparam int PIN_MODE    = 0;
    localparam int PIN_SHDN_N  = 1;
    localparam int PIN_BEEP_EN = 2;
    localparam int PIN_BEEP    = 3;
    localparam int PIN_SCL     = 4;
    localparam int PIN_SDA     = 5;
    localparam int PIN_STRAP0  = 6;
    localparam int PIN_STRAP1  = 7;
    localparam int PIN_W       = 8;
    // Idle pin levels: bus lines high, shutdown released
    localparam logic [PIN_W-1:0] PIN_IDLE = 8'h32;

    // Subaddresses
    localparam logic [2:0] SUB_L_BRIDGED = 3'h0;
    localparam logic [2:0] SUB_R_BRIDGED = 3'h1;
    localparam logic [2:0] SUB_L_SE      = 3'h2;
    localparam logic [2:0] SUB_R_SE      = 3'h3;
    localparam logic [2:0] SUB_CTRL      = 3'h4;
    localparam int         GAIN_REGS     = 4;

    // Gain byte: code 0 is -60 dB bridged, -66 dB single-ended
    localparam int GAIN_BRIDGED_RESET_DB = -60;
    localparam int GAIN_SE_RESET_DB      = -66;
    localparam int GAIN_STEP_MDB         = 1250;
    localparam int GAIN_CODE_MSB         = 5;
    localparam int MUTE_LSB              = 6;
    localparam int MUTE_MSB              = 7;
    localparam logic [7:0] GAIN_RESET    = 8'h00;

    // Control byte
    localparam int CTRL_MODE_OVR_BIT  = 0;
    localparam int CTRL_MODE_SE_BIT   = 1;
    localparam int CTRL_BEEP_BIT      = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Upper bits of the bus address; value is arbitrary
    localparam logic [4:0] DEV_ADDR_HI_DEFAULT = 5'h1a;

    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    localparam logic [3:0] BIT_CNT_ACK  = 4'h8;
    localparam logic [1:0] STRAP_LAST   = 2'h2;
    localparam logic [1:0] STRAP_DONE   = 2'h3;

    typedef enum logic [2:0] {
        PH_ADDR   = 3'b000,
        PH_SUB    = 3'b001,
        PH_WDATA  = 3'b010,
        PH_RDATA  = 3'b011,
        PH_IGNORE = 3'b100
    } ampc_phase_t;

endpackage : ampc_pkg

/* File: rtl/ampc_pin_if.sv */
// Carrier for raw pins, their synchronised copies and the beep flag.
// Assumes the top drives raw and the leaf modules use their modports.
`timescale 1ns/1ps
interface ampc_pin_if;
    import ampc_pkg::*;
    logic [PIN_W-1:0] raw;
    logic [PIN_W-1:0] synced;
    logic             beepSeen;

    modport sync (input raw, output synced);
    modport det  (input synced, output beepSeen);
endinterface : ampc_pin_if

/* File: rtl/ampc_sync.sv */
// Two-flop synchroniser for every asynchronous pin.
// Assumes pins change slowly compared with clk.
`timescale 1ns/1ps
module ampc_sync
    import ampc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    ampc_pin_if.sync pins
);
    logic [PIN_W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // Idle levels, so no false shutdown or bus edge follows reset
            meta_r       <= PIN_IDLE;
            pins.synced  <= PIN_IDLE;
        end else begin
            meta_r       <= pins.raw;
            pins.synced  <= meta_r;
        end
    end
endmodule : ampc_sync

/* File: rtl/ampc_beep_det.sv */
// Beep detector: a square wave on the comparator output of the beep pin.
// Assumes the pad comparator trips at the 1 V peak-to-peak level.
`timescale 1ns/1ps
module ampc_beep_det
    import ampc_pkg::*;
#(
    parameter int GAP_CYC = BEEP_GAP_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    ampc_pin_if.det  pins
);
    localparam int GW = $clog2(GAP_CYC + 1);

    logic          prev_r;
    logic [GW-1:0] gap_r;
    logic [1:0]    edges_r;
    logic          toggle;

    assign toggle = pins.synced[PIN_BEEP] ^ prev_r;

    // A lone edge is not a beep; several close edges are
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_r  <= 1'b0;
            gap_r   <= '0;
            edges_r <= 2'h0;
        end else begin
            prev_r <= pins.synced[PIN_BEEP];
            if (toggle) begin
                gap_r <= '0;
                if (edges_r != BEEP_MIN_EDGES) begin
                    edges_r <= edges_r + 2'h1;
                end
            end else if (gap_r == GW'(GAP_CYC - 1)) begin
                edges_r <= 2'h0;
            end else begin
                gap_r <= gap_r + GW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pins.beepSeen <= 1'b0;
        end else begin
            pins.beepSeen <= (edges_r == BEEP_MIN_EDGES);
        end
    end
endmodule : ampc_beep_det

/* File: rtl/ampc_top.sv */
// Control logic of a stereo amplifier: gain/mute registers on a two-wire
// bus, input/output mode selection, shutdown and beep control.
// Assumes scl/sda pads give digital levels; sda is open drain.
`timescale 1ns/1ps

// Contract
// - Gains reset to -60 dB bridged, -66 single-ended
// - Four bus-written gain registers, one per channel/mode
// - Six-bit gain code, 64 steps of 1.25 dB
// - Two mute bits silence the governed path
// - Address bit 0 from first strap pin
// - Address bit 1 from second strap pin
// - Mode pin high: headphone inputs, single-ended output
// - Mode pin low: line inputs, bridged output
// - Bus write may select mode instead of pin
// - Negative leg floats single-ended, driven when bridged
// - Shutdown pin low: amp off, beep, bus alive
// - Beep on square wave, enable pin or bus
module ampc_top
    import ampc_pkg::*;
#(
    parameter int         BEEP_GAP    = BEEP_GAP_CYC,
    parameter logic [4:0] DEV_ADDR_HI = DEV_ADDR_HI_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       outputModeSelect,
    input  wire logic       shutdown_n,
    input  wire logic       beepEnablePin,
    input  wire logic       beepInput,
    input  wire logic       addrStrapLsb,
    input  wire logic       addrStrapMsb,
    output logic            singleEndedMode,
    output logic            bridgedMode,
    output logic            headphoneInSel,
    output logic            lineInSel,
    output logic            leftOutNegativeOe,
    output logic            rightOutNegativeOe,
    output logic [5:0]      leftGain,
    output logic [5:0]      rightGain,
    output logic            leftMute,
    output logic            rightMute,
    output logic            ampEnable,
    output logic            shutdownMode,
    output logic            beepMode
);
    ampc_pin_if pins ();

    assign pins.raw = {addrStrapMsb, addrStrapLsb, sdaIn, scl,
                       beepInput, beepEnablePin, shutdown_n,
                       outputModeSelect};

    ampc_sync u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (pins.sync)
    );

    ampc_beep_det #(
        .GAP_CYC (BEEP_GAP)
    ) u_beep (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (pins.det)
    );

    logic modeSync;
    logic shdnSync_n;
    logic beepEnSync;
    logic sclSync;
    logic sdaSync;

    assign modeSync   = pins.synced[PIN_MODE];
    assign shdnSync_n = pins.synced[PIN_SHDN_N];
    assign beepEnSync = pins.synced[PIN_BEEP_EN];
    assign sclSync    = pins.synced[PIN_SCL];
    assign sdaSync    = pins.synced[PIN_SDA];

    // Frame tracking in the system domain
    logic sclPrev_r;
    logic sdaPrev_r;
    logic busBusy_r;
    logic linkRst_r;
    logic linkPor_r;
    logic startCond;
    logic stopCond;
    logic sclFall;

    assign startCond = sclSync & sclPrev_r & sdaPrev_r & ~sdaSync;
    assign stopCond  = sclSync & sclPrev_r & ~sdaPrev_r & sdaSync;
    assign sclFall   = sclPrev_r & ~sclSync;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclPrev_r <= 1'b0;
            sdaPrev_r <= 1'b1;
        end else begin
            sclPrev_r <= sclSync;
            sdaPrev_r <= sdaSync;
        end
    end

    // Link logic is held reset between frames; scl stands still then
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busBusy_r <= 1'b0;
            linkRst_r <= 1'b1;
            linkPor_r <= 1'b1;
        end else begin
            linkPor_r <= 1'b0;
            if (startCond) begin
                busBusy_r <= 1'b1;
            end else if (stopCond) begin
                busBusy_r <= 1'b0;
            end
            if (startCond || stopCond) begin
                linkRst_r <= 1'b1;
            end else if (busBusy_r && sclFall) begin
                linkRst_r <= 1'b0;
            end
        end
    end

    // Register file and strap capture
    logic [7:0] gainReg_r [GAIN_REGS];
    logic [7:0] ctrl_r;
    logic [6:0] devAddr_r;
    logic [1:0] strapCnt_r;
    logic [2:0] wrSync_r;
    logic       wrStrobe;

    // Link side, clocked by scl
    ampc_phase_t phase_r;
    logic [3:0]  bitCnt_r;
    logic [7:0]  shift_r;
    logic        ackNow_r;
    logic [2:0]  subAddr_r;
    logic [2:0]  wrAddr_r;
    logic [7:0]  wrData_r;
    logic        wrToggle_r;
    logic [7:0]  txShift_r;
    logic [7:0]  rxByte;
    logic [7:0]  rdByte;
    logic        addrHit;

    assign rxByte  = {shift_r[6:0], sdaIn};
    assign addrHit = (rxByte[7:1] == devAddr_r);

    always_ff @(posedge scl or posedge linkRst_r) begin
        if (linkRst_r) begin
            bitCnt_r  <= 4'h0;
            shift_r   <= 8'h00;
            phase_r   <= PH_ADDR;
            ackNow_r  <= 1'b0;
        end else if (bitCnt_r == BIT_CNT_ACK) begin
            bitCnt_r <= 4'h0;
            ackNow_r <= 1'b0;
            if (phase_r == PH_RDATA && sdaIn) begin
                phase_r <= PH_IGNORE;
            end
        end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r  <= rxByte;
            if (bitCnt_r == BIT_CNT_LAST) begin
                unique case (phase_r)
                    PH_ADDR: begin
                        ackNow_r <= addrHit;
                        if (!addrHit) begin
                            phase_r <= PH_IGNORE;
                        end else if (rxByte[0]) begin
                            phase_r <= PH_RDATA;
                        end else begin
                            phase_r <= PH_SUB;
                        end
                    end
                    PH_SUB: begin
                        ackNow_r <= 1'b1;
                        phase_r  <= PH_WDATA;
                    end
                    PH_WDATA: begin
                        ackNow_r <= 1'b1;
                    end
                    PH_RDATA, PH_IGNORE: begin
                        ackNow_r <= 1'b0;
                    end
                    default: begin
                        phase_r <= PH_IGNORE;
                    end
                endcase
            end
        end
    end

    // Toggle survives frame resets so no false write edge appears
    always_ff @(posedge scl or posedge linkPor_r) begin
        if (linkPor_r) begin
            wrAddr_r   <= 3'h0;
            wrData_r   <= 8'h00;
            wrToggle_r <= 1'b0;
        end else if (bitCnt_r == BIT_CNT_LAST && phase_r == PH_WDATA) begin
            wrAddr_r   <= subAddr_r;
            wrData_r   <= rxByte;
            wrToggle_r <= ~wrToggle_r;
        end
    end

    // Subaddress outlives frame resets so a read resumes where the
    // preceding write frame left it; the address ack never moves it
    always_ff @(posedge scl or posedge linkPor_r) begin
        if (linkPor_r) begin
            subAddr_r <= 3'h0;
        end else if (bitCnt_r == BIT_CNT_LAST) begin
            if (phase_r == PH_SUB) begin
                subAddr_r <= rxByte[2:0];
            end else if (phase_r == PH_WDATA || phase_r == PH_RDATA) begin
                subAddr_r <= subAddr_r + 3'h1;
            end
        end
    end

    // Register words are quasi-static: they only change on a write that
    // this link made, many scl edges before the next read bit
    always_comb begin
        rdByte = 8'h00;
        if (subAddr_r < SUB_CTRL) begin
            rdByte = gainReg_r[subAddr_r[1:0]];
        end else if (subAddr_r == SUB_CTRL) begin
            rdByte = ctrl_r;
        end
    end

    // Change the sda drive only on scl falling edges; it holds through scl high
    always_ff @(negedge scl or posedge linkRst_r) begin
        if (linkRst_r) begin
            sdaOe     <= 1'b0;
            txShift_r <= 8'h00;
        end else if (bitCnt_r == BIT_CNT_ACK) begin
            sdaOe <= ackNow_r;
        end else if (phase_r == PH_RDATA) begin
            if (bitCnt_r == 4'h0) begin
                sdaOe     <= ~rdByte[7];
                txShift_r <= {rdByte[6:0], 1'b0};
            end else begin
                sdaOe     <= ~txShift_r[7];
                txShift_r <= {txShift_r[6:0], 1'b0};
            end
        end else begin
            sdaOe <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
    end

    // Write event crossing; data is held stable by the link meanwhile
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrSync_r <= 3'h0;
        end else begin
            wrSync_r <= {wrSync_r[1:0], wrToggle_r};
        end
    end

    assign wrStrobe = wrSync_r[2] ^ wrSync_r[1];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < GAIN_REGS; i++) begin
                gainReg_r[i] <= GAIN_RESET;
            end
            ctrl_r <= CTRL_RESET;
        end else if (wrStrobe) begin
            if (wrAddr_r < SUB_CTRL) begin
                gainReg_r[wrAddr_r[1:0]] <= wrData_r;
            end else if (wrAddr_r == SUB_CTRL) begin
                ctrl_r <= wrData_r;
            end
        end
    end

    // Straps are read once after reset, once the synchroniser is full
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strapCnt_r <= 2'h0;
            devAddr_r  <= {DEV_ADDR_HI, 2'b00};
        end else begin
            if (strapCnt_r != STRAP_DONE) begin
                strapCnt_r <= strapCnt_r + 2'h1;
            end
            if (strapCnt_r == STRAP_LAST) begin
                devAddr_r <= {DEV_ADDR_HI, pins.synced[PIN_STRAP1],
                              pins.synced[PIN_STRAP0]};
            end
        end
    end

    // Mode and gain selection
    logic       seMode;
    logic [7:0] leftSel;
    logic [7:0] rightSel;

    assign seMode   = ctrl_r[CTRL_MODE_OVR_BIT] ?
                      ctrl_r[CTRL_MODE_SE_BIT] : modeSync;
    assign leftSel  = seMode ? gainReg_r[SUB_L_SE[1:0]]
                             : gainReg_r[SUB_L_BRIDGED[1:0]];
    assign rightSel = seMode ? gainReg_r[SUB_R_SE[1:0]]
                             : gainReg_r[SUB_R_BRIDGED[1:0]];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            singleEndedMode    <= 1'b0;
            bridgedMode        <= 1'b1;
            headphoneInSel     <= 1'b0;
            lineInSel          <= 1'b1;
            leftOutNegativeOe  <= 1'b1;
            rightOutNegativeOe <= 1'b1;
        end else begin
            singleEndedMode    <= seMode;
            bridgedMode        <= ~seMode;
            headphoneInSel     <= seMode;
            lineInSel          <= ~seMode;
            leftOutNegativeOe  <= ~seMode;
            rightOutNegativeOe <= ~seMode;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            leftGain  <= GAIN_RESET[GAIN_CODE_MSB:0];
            rightGain <= GAIN_RESET[GAIN_CODE_MSB:0];
            leftMute  <= 1'b0;
            rightMute <= 1'b0;
        end else begin
            leftGain  <= leftSel[GAIN_CODE_MSB:0];
            rightGain <= rightSel[GAIN_CODE_MSB:0];
            leftMute  <= |leftSel[MUTE_MSB:MUTE_LSB];
            rightMute <= |rightSel[MUTE_MSB:MUTE_LSB];
        end
    end

    // Shutdown leaves beep path and bus running
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shutdownMode <= 1'b0;
            ampEnable    <= 1'b0;
            beepMode     <= 1'b0;
        end else begin
            shutdownMode <= ~shdnSync_n;
            ampEnable    <= shdnSync_n;
            beepMode     <= pins.beepSeen | beepEnSync
                          | ctrl_r[CTRL_BEEP_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_pinSe;
        modeSync && !ctrl_r[CTRL_MODE_OVR_BIT];
    endsequence

    sequence s_pinBtl;
        !modeSync && !ctrl_r[CTRL_MODE_OVR_BIT];
    endsequence

    sequence s_shdnWithBeep;
        !shdnSync_n && beepEnSync;
    endsequence

    a_reset_gain: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |=> (gainReg_r[0] == GAIN_RESET) && (leftGain == 6'h00)
                     && (gainReg_r[3] == GAIN_RESET) && !leftMute)
        else $error("gain not at reset code after reset");

    a_write_lands: assert property (
        (wrStrobe && wrAddr_r < SUB_CTRL)
        |=> gainReg_r[$past(wrAddr_r[1:0])] == $past(wrData_r))
        else $error("bus write did not reach gain register");

    a_gain_code: assert property (
        ##1 (leftGain == $past(leftSel[GAIN_CODE_MSB:0]))
            && (rightGain == $past(rightSel[GAIN_CODE_MSB:0])))
        else $error("gain output not from active mode register");

    a_mute_bits: assert property (
        ##1 (leftMute == $past(|leftSel[MUTE_MSB:MUTE_LSB]))
            && (rightMute == $past(|rightSel[MUTE_MSB:MUTE_LSB])))
        else $error("mute output does not follow mute bits");

    a_strap_lsb: assert property (
        (strapCnt_r == STRAP_LAST)
        |=> devAddr_r[0] == $past(pins.synced[PIN_STRAP0]))
        else $error("address bit 0 not taken from strap");

    a_strap_msb: assert property (
        (strapCnt_r == STRAP_LAST)
        |=> devAddr_r[1] == $past(pins.synced[PIN_STRAP1]))
        else $error("address bit 1 not taken from strap");

    a_pin_se: assert property (
        s_pinSe |=> singleEndedMode && headphoneInSel && !lineInSel)
        else $error("mode pin high did not select single-ended");

    a_pin_btl: assert property (
        s_pinBtl |=> bridgedMode && lineInSel && !headphoneInSel)
        else $error("mode pin low did not select bridged");

    a_bus_mode: assert property (
        ctrl_r[CTRL_MODE_OVR_BIT]
        |=> singleEndedMode == $past(ctrl_r[CTRL_MODE_SE_BIT]))
        else $error("bus mode selection ignored");

    a_neg_leg: assert property (
        (leftOutNegativeOe == bridgedMode)
        && (rightOutNegativeOe == bridgedMode)
        && (singleEndedMode != bridgedMode))
        else $error("negative leg enable disagrees with mode");

    a_shdn_beep: assert property (
        s_shdnWithBeep |=> shutdownMode && !ampEnable && beepMode)
        else $error("shutdown stopped the beep path");

    a_beep_req: assert property (
        (beepEnSync || ctrl_r[CTRL_BEEP_BIT] || pins.beepSeen)
        |=> beepMode)
        else $error("beep request did not enter beep mode");

endmodule : ampc_top

/* File: testbench/ampc_bus_host.sv */
// Behavioural two-wire bus controller, the far side of the link.
// Assumes an external pull-up resolves sda from all pull-downs.
`timescale 1ns/1ps
module ampc_bus_host (
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaPull
);
    // Link clock stands high between frames; bit period 30 ns
    initial begin
        scl     = 1'b1;
        sdaPull = 1'b0;
    end

    // Data moves only while scl is low
    task automatic bit_xfer(input logic b, output logic s);
        #5 sdaPull = !b;
        #10 scl = 1'b1;
        s = sdaLine;
        #15 scl = 1'b0;
    endtask : bit_xfer

    // Extra low time so the system clock sees the start first
    task automatic start;
        #5 sdaPull = 1'b0;
        #10 scl = 1'b1;
        #15 sdaPull = 1'b1;
        #15 scl = 1'b0;
        #10;
    endtask : start

    task automatic stop;
        #5 sdaPull = 1'b1;
        #10 scl = 1'b1;
        #15 sdaPull = 1'b0;
        #30;
    endtask : stop

    // Gains reach the device only by writes; mode selection also by its pin
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = !s;
    endtask : send

    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(last, s);
    endtask : recv
endmodule : ampc_bus_host

/* File: testbench/tb_amp_control_register_logic.sv */
// Self-checking bench of the amplifier control logic.
// Assumes ampc_top and the bus controller model; straps give bits 01.
`timescale 1ns/1ps
module tb_amp_control_register_logic
    import ampc_pkg::*;
;
    localparam logic [6:0] ADR = {DEV_ADDR_HI_DEFAULT, 2'b01};
    localparam logic [7:0] BRG = 8'h2b;
    localparam logic [7:0] SEM = 8'h14;
    localparam logic [7:0] CTL = {5'h0, SUB_CTRL};

    logic clk = 1'b0, reset_n = 1'b0, modeSel = 1'b0, shutdown_n = 1'b1;
    logic beepEnablePin = 1'b0, beepInput = 1'b0;
    logic scl, sdaPull, sdaOut, sdaOe, singleEndedMode, bridgedMode;
    logic headphoneInSel, lineInSel, leftOutNegativeOe, rightOutNegativeOe;
    logic [5:0] leftGain, rightGain;
    logic leftMute, rightMute, ampEnable, shutdownMode, beepMode;
    int miscompares = 0;
    int n_tests = 0;

    // Open drain with pull-up: low if any party pulls
    wire sdaLine = !((sdaOe && !sdaOut) || sdaPull);
    wire [7:0] modeVec = {2'h0, bridgedMode, singleEndedMode, lineInSel,
        headphoneInSel, leftOutNegativeOe, rightOutNegativeOe};
    wire [15:0] gainVec = {leftMute, 1'b0, leftGain,
        rightMute, 1'b0, rightGain};
    wire [7:0] pwrVec = {5'h0, ampEnable, shutdownMode, beepMode};

    always #2.5 clk = ~clk;

    // Short beep gap keeps the run brief
    ampc_top #(.BEEP_GAP(50)) DUT (.clk, .reset_n, .scl, .sdaIn(sdaLine),
        .sdaOut, .sdaOe, .outputModeSelect(modeSel), .shutdown_n,
        .beepEnablePin, .beepInput, .addrStrapLsb(1'b1),
        .addrStrapMsb(1'b0), .singleEndedMode, .bridgedMode,
        .headphoneInSel, .lineInSel, .leftOutNegativeOe,
        .rightOutNegativeOe, .leftGain, .rightGain, .leftMute,
        .rightMute, .ampEnable, .shutdownMode, .beepMode);

    ampc_bus_host host (.sdaLine, .scl, .sdaPull);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] b[$]);
        logic a;
        host.start;
        host.send({ADR, 1'b0}, a);
        check(a, 1'b1);
        foreach (b[i]) begin
            host.send(b[i], a);
            check(a, 1'b1);
        end
        host.stop;
        cyc(10);
    endtask : wr

    task automatic rd(input logic [2:0] sub, input logic [7:0] exp);
        logic       a;
        logic [7:0] d;
        wr('{{5'h0, sub}});
        host.start;
        host.send({ADR, 1'b1}, a);
        check(a, 1'b1);
        host.recv(1'b1, d);
        host.stop;
        check(d, exp);
    endtask : rd

    // Wrong strap bits must not be acknowledged
    task automatic t_addr;
        logic a;
        for (int i = 0; i < 4; i += 3) begin
            host.start;
            host.send({DEV_ADDR_HI_DEFAULT, i[1:0], 1'b0}, a);
            check(a, 1'b0);
            host.stop;
        end
    endtask : t_addr

    task automatic t_reset;
        for (int i = 0; i < GAIN_REGS; i++) begin
            rd(i[2:0], GAIN_RESET);
        end
        check(pwrVec, 8'h04);
        check(sdaOut, 1'b0);
        modeSel = 1'b1;
        cyc(4);
        check(modeVec, SEM);
        check(gainVec, 16'h0000);
        modeSel = 1'b0;
        cyc(4);
        check(modeVec, BRG);
    endtask : t_reset

    // Max code, both mute bits, auto-increment across all four
    task automatic t_gains;
        wr('{8'h00, 8'h3f, 8'h55, 8'h81, 8'h2a});
        check(gainVec, 16'h3f95);
        // Unused subaddress: acknowledged, dropped, reads back zero
        wr('{8'h05, 8'hee});
        rd(3'h5, 8'h00);
        check(gainVec, 16'h3f95);
        modeSel = 1'b1;
        cyc(4);
        check(gainVec, 16'h812a);
        modeSel = 1'b0;
        cyc(4);
        rd(SUB_R_BRIDGED, 8'h55);
    endtask : t_gains

    task automatic t_override;
        wr('{CTL, 8'h03});
        check(modeVec, SEM);
        modeSel = 1'b1;
        wr('{CTL, 8'h01});
        check(modeVec, BRG);
        wr('{CTL, 8'h00});
        check(modeVec, SEM);
        modeSel = 1'b0;
        cyc(4);
    endtask : t_override

    task automatic t_shutdown;
        shutdown_n = 1'b0;
        cyc(4);
        check(pwrVec, 8'h02);
        beepEnablePin = 1'b1;
        cyc(4);
        check(pwrVec, 8'h03);
        beepEnablePin = 1'b0;
        rd(SUB_L_BRIDGED, 8'h3f);
        shutdown_n = 1'b1;
        cyc(4);
        check(pwrVec, 8'h04);
    endtask : t_shutdown

    task automatic t_beep;
        wr('{CTL, 8'h04});
        check(pwrVec, 8'h05);
        wr('{CTL, 8'h00});
        check(pwrVec, 8'h04);
        repeat (6) begin
            beepInput = !beepInput;
            cyc(10);
        end
        check(pwrVec, 8'h05);
        cyc(60);
        check(pwrVec, 8'h04);
    endtask : t_beep

    initial begin
        cyc(2);
        reset_n = 1'b1;
        cyc(1);
        check(modeVec, BRG);
        check(gainVec, 16'h0000);
        check(pwrVec, 8'h04);
        cyc(5);
        t_reset();
        t_addr();
        t_gains();
        t_override();
        t_shutdown();
        t_beep();
        wrap_up();
    end

    // Hang guard: roughly 80000 clock cycles
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_amp_control_register_logic
